/* File: rtl/dsfs_consts.vh */
/*
 Constants for the drive sequence and fault supervisor: state codes,
 fault source indices, timing counts.
 Assumes a 125 MHz clk; included by its bare name.
*/
// ============================================================
`ifndef DSFS_CONSTS_VH
`define DSFS_CONSTS_VH

// ============================================================
// Sequencer states
`define DSFS_ST_OFF      3'h0
`define DSFS_ST_READY    3'h1
`define DSFS_ST_RUN      3'h2
`define DSFS_ST_BRAKE    3'h3
`define DSFS_ST_HOLD     3'h4
`define DSFS_ST_ZERO     3'h5
`define DSFS_ST_FAULT    3'h6
`define DSFS_ST_LOCK     3'h7

// ============================================================
// Fault sources (restartable ones occupy bits 0..4)
`define DSFS_NFAULT      8
`define DSFS_RESTART_MSK 8'h1f
`define DSFS_DIS_RESET   8'h80

// ============================================================
// Timing: one millisecond tick
`define DSFS_CLK_KHZ     125000
`define DSFS_MS_CYC      `DSFS_CLK_KHZ
`define DSFS_RESTART_MAX 16'h07d0
`define DSFS_TR_MIN_MS   16'h0003
`define DSFS_TR_MAX_MS   16'h012c
`define DSFS_JOG_MAX_MS  16'hea60

// ============================================================
// Trace and history sizes, i2t alarm level
`define DSFS_TR_CH       10
`define DSFS_TR_DEPTH    128
`define DSFS_HIST_DEPTH  8
`define DSFS_I2T_FULL    16'h0064

`endif

/* File: rtl/dsfs_mem.v */
/*
 Simple dual port memory with registered read data, used for the
 trace samples. Assumes one clock and synchronous access.
*/
`timescale 1ns/1ps
module dsfs_mem #(
   parameter AW = 11,
   parameter DW = 16
) (
   input  wire          clk,
   input  wire          we,
   input  wire [AW-1:0] waddr,
   input  wire [DW-1:0] wdata,
   input  wire [AW-1:0] raddr,
   output reg  [DW-1:0] rdata
);
   reg [DW-1:0] mem [0:(1<<AW)-1];

   always @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule

/* File: rtl/dsfs_top.v */
/*
 Sequence control, fault supervision, fault history and trace memory
 of a DC drive converter. Assumes all inputs from terminals and the
 panel are asynchronous and are synchronised here, as are the
 speed and current flags; measured values come in as plain levels.
*/
`timescale 1ns/1ps
`include "dsfs_consts.vh"
module dsfs_top #(
   parameter MS_CYC = `DSFS_MS_CYC
) (
   input  wire         clk,
   input  wire         rst_b,
   input  wire         term_on,
   input  wire         ser_on,
   input  wire         term_enable,
   input  wire         ser_enable,
   input  wire         coast_stop_command_b,
   input  wire         quick_stop_command_b,
   input  wire         jog_request,
   input  wire         jog_use_ramp,
   input  wire         speed_below_min,
   input  wire         current_zero,
   input  wire [15:0]  brake_delay_ms,
   input  wire [15:0]  field_delay_ms,
   input  wire [15:0]  jog_off_delay_ms,
   input  wire [15:0]  restart_ms,
   input  wire [7:0]   fault_src,
   input  wire [7:0]   fault_dis_clr,
   input  wire [7:0]   fault_dis_set,
   input  wire [15:0]  fault_value,
   input  wire         ack_panel,
   input  wire         ack_input,
   input  wire         ack_serial,
   input  wire [3:0]   alarm_src,
   input  wire [15:0]  motor_i2t,
   input  wire [31:0]  hours_count,
   input  wire [159:0] trace_in,
   input  wire [3:0]   trace_trig_ch,
   input  wire [15:0]  trace_trig_level,
   input  wire         trace_trig_on_fault,
   input  wire [6:0]   trace_delay,
   input  wire [15:0]  trace_interval_ms,
   input  wire         trace_arm,
   input  wire [10:0]  trace_raddr,
   input  wire [2:0]   hist_sel,
   output reg          contactor_on,
   output reg          ctrl_enable,
   output reg          force_zero_current,
   output reg          pulse_enable,
   output reg          speed_set_zero,
   output reg          quick_limit_sel,
   output reg          jog_active,
   output reg          ramp_bypass,
   output reg          field_standstill,
   output reg          fault_out_b,
   output reg          alarm_out_b,
   output reg          fault_led,
   output reg  [7:0]   fault_number,
   output reg  [31:0]  fault_time,
   output reg  [7:0]   hist_number,
   output reg  [15:0]  hist_value,
   output reg  [31:0]  hist_hours,
   output reg          trace_done,
   output wire [15:0]  trace_rdata
);
   // =========================================================
   // Input synchronisers
   localparam NS = 8 + 8 + 3 + 4 + 3;
   wire [NS-1:0] raw_w;
   reg  [NS-1:0] s1_q;
   reg  [NS-1:0] s2_q;
   assign raw_w = {term_on, ser_on, term_enable, ser_enable,
                   coast_stop_command_b, quick_stop_command_b,
                   jog_request, speed_below_min, fault_src,
                   ack_panel, ack_input, ack_serial, alarm_src,
                   current_zero, jog_use_ramp, trace_arm};
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_q <= {NS{1'b0}};
         s2_q <= {NS{1'b0}};
      end else begin
         s1_q <= raw_w;
         s2_q <= s1_q;
      end
   end
   wire       on_w    = s2_q[25] & s2_q[24];
   wire       en_w    = s2_q[23] & s2_q[22];
   wire       coast_w = ~s2_q[21];
   wire       quick_w = ~s2_q[20];
   wire       jog_w   = s2_q[19];
   wire       nmin_w  = s2_q[18];
   wire [7:0] fsrc_w  = s2_q[17:10];
   wire       ack_w   = |s2_q[9:7];
   wire [3:0] alm_w   = s2_q[6:3];
   wire       izero_w = s2_q[2];
   wire       jramp_w = s2_q[1];
   wire       arm_w   = s2_q[0];

   // =========================================================
   // Millisecond tick
   reg [31:0] div_q;
   wire       ms_w = (div_q == MS_CYC - 1);
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         div_q <= 32'h0;
      end else begin
         div_q <= ms_w ? 32'h0 : div_q + 32'h1;
      end
   end

   // =========================================================
   // Fault disables and detection
   reg  [7:0] dis_q;
   reg  [7:0] pend_q;
   reg [15:0] rst_ms_q;
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dis_q <= `DSFS_DIS_RESET;
      end else begin
         dis_q <= (dis_q & ~fault_dis_clr) | fault_dis_set;
      end
   end
   wire [7:0] act_w = fsrc_w & ~dis_q;
   wire [7:0] rst_w = act_w & `DSFS_RESTART_MSK;
   wire [15:0] win_w = (restart_ms > `DSFS_RESTART_MAX) ?
                       `DSFS_RESTART_MAX : restart_ms;
   // A restartable fault only trips once it outlasts the window
   wire rs_trip_w = (|rst_w) & ((win_w == 16'h0) ||
                    (ms_w && rst_ms_q >= win_w - 16'h1));
   wire trip_w = (|(act_w & ~`DSFS_RESTART_MSK)) | rs_trip_w;
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_ms_q <= 16'h0;
      end else if (~|rst_w) begin
         rst_ms_q <= 16'h0;
      end else if (ms_w) begin
         rst_ms_q <= rst_ms_q + 16'h1;
      end
   end
   reg [2:0] idx_d;
   integer   k;
   always @* begin
      idx_d = 3'h0;
      for (k = `DSFS_NFAULT - 1; k >= 0; k = k - 1) begin
         if (act_w[k]) begin
            idx_d = k[2:0];
         end
      end
   end

   // =========================================================
   // Sequencer
   reg  [2:0] st_q;
   reg [15:0] tmr_q;
   reg        jog_q;
   wire       tdone_w;
   wire       in_fault_w = (st_q == `DSFS_ST_FAULT);
   wire [15:0] stop_dly_w = jog_q ? ((jog_off_delay_ms >
                     `DSFS_JOG_MAX_MS) ? `DSFS_JOG_MAX_MS :
                     jog_off_delay_ms) : brake_delay_ms;
   assign tdone_w = (tmr_q == 16'h0);
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q  <= `DSFS_ST_OFF;
         tmr_q <= 16'h0;
         jog_q <= 1'b0;
      end else if (trip_w && !in_fault_w) begin
         st_q <= `DSFS_ST_FAULT;
      end else begin
         if (ms_w && !tdone_w) begin
            tmr_q <= tmr_q - 16'h1;
         end
         case (st_q)
         `DSFS_ST_OFF, `DSFS_ST_READY: begin
            // A held coast or quick stop must not re-close the contactor
            if (coast_w || quick_w) begin
               st_q <= `DSFS_ST_OFF;
            end else if (on_w) begin
               st_q  <= `DSFS_ST_RUN;
               jog_q <= 1'b0;
            end else if (en_w && jog_w) begin
               st_q  <= `DSFS_ST_RUN;
               jog_q <= 1'b1;
            end
         end
         `DSFS_ST_RUN: begin
            if (coast_w || (!en_w && ctrl_enable)) begin
               st_q <= `DSFS_ST_ZERO;
            end else if (quick_w || (jog_q ? !jog_w : !on_w)) begin
               st_q <= `DSFS_ST_BRAKE;
            end
         end
         `DSFS_ST_BRAKE: begin
            if (coast_w || !en_w) begin
               st_q <= `DSFS_ST_ZERO;
            end else if (nmin_w) begin
               st_q  <= `DSFS_ST_HOLD;
               tmr_q <= stop_dly_w;
            end
         end
         `DSFS_ST_HOLD: begin
            if (coast_w || !en_w || tdone_w) begin
               st_q <= `DSFS_ST_ZERO;
            end
         end
         `DSFS_ST_ZERO: begin
            if (izero_w) begin
               st_q  <= `DSFS_ST_OFF;
               tmr_q <= field_delay_ms;
            end
         end
         `DSFS_ST_FAULT: begin
            if (ack_w && !trip_w) begin
               st_q <= `DSFS_ST_LOCK;
            end
         end
         default: begin
            if (!on_w) begin
               st_q <= `DSFS_ST_OFF;
            end
         end
         endcase
      end
   end

   // =========================================================
   // Sequencer outputs and indication
   reg [8:0] blink_q;
   wire run_w   = (st_q == `DSFS_ST_RUN);
   wire brk_w   = (st_q == `DSFS_ST_BRAKE);
   wire hold_w  = (st_q == `DSFS_ST_HOLD);
   wire zero_w  = (st_q == `DSFS_ST_ZERO);
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         contactor_on       <= 1'b0;
         ctrl_enable        <= 1'b0;
         force_zero_current <= 1'b1;
         pulse_enable       <= 1'b0;
         speed_set_zero     <= 1'b1;
         quick_limit_sel    <= 1'b0;
         jog_active         <= 1'b0;
         ramp_bypass        <= 1'b0;
         field_standstill   <= 1'b1;
         fault_out_b        <= 1'b1;
         alarm_out_b        <= 1'b1;
         fault_led          <= 1'b0;
         blink_q            <= 9'h0;
      end else begin
         if (ms_w) begin
            blink_q <= blink_q + 9'h1;
         end
         // Contactor stays in through zero-current decay
         contactor_on <= run_w | brk_w | hold_w | zero_w;
         // Jog release drops the controllers at the start of the off delay
         ctrl_enable  <= (run_w | brk_w | (hold_w & ~jog_q)) & en_w
                         & ~coast_w;
         force_zero_current <= ~(run_w | brk_w | (hold_w & ~jog_q)) |
                               ~en_w | coast_w;
         pulse_enable <= (run_w | brk_w | hold_w) |
                         (zero_w & ~izero_w);
         speed_set_zero  <= ~run_w | quick_w;
         quick_limit_sel <= quick_w & (run_w | brk_w);
         jog_active  <= jog_q & run_w;
         ramp_bypass <= jog_q & run_w & ~jramp_w;
         field_standstill <= (st_q == `DSFS_ST_OFF ||
                              st_q == `DSFS_ST_FAULT ||
                              st_q == `DSFS_ST_LOCK) &&
                             tdone_w;
         fault_out_b <= ~in_fault_w;
         alarm_out_b <= ~(|alm_w | (motor_i2t >=
                          `DSFS_I2T_FULL));
         fault_led   <= in_fault_w |
                        ((|alm_w | (motor_i2t >= `DSFS_I2T_FULL))
                         & blink_q[8]);
      end
   end

   // =========================================================
   // Fault number, time stamp and history ring
   reg  [7:0] h_num_q [0:`DSFS_HIST_DEPTH-1];
   reg [15:0] h_val_q [0:`DSFS_HIST_DEPTH-1];
   reg [31:0] h_hrs_q [0:`DSFS_HIST_DEPTH-1];
   reg  [2:0] h_wp_q;
   wire       log_w = trip_w && !in_fault_w;
   wire [2:0] h_rd_w = h_wp_q - 3'h1 - hist_sel;
   genvar g;
   generate
      for (g = 0; g < `DSFS_HIST_DEPTH; g = g + 1) begin : hist
         always @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               h_num_q[g] <= 8'h0;
               h_val_q[g] <= 16'h0;
               h_hrs_q[g] <= 32'h0;
            end else if (log_w && h_wp_q == g) begin
               h_num_q[g] <= {5'h0, idx_d} + 8'h1;
               h_val_q[g] <= fault_value;
               h_hrs_q[g] <= hours_count;
            end
         end
      end
   endgenerate
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         h_wp_q       <= 3'h0;
         fault_number <= 8'h0;
         fault_time   <= 32'h0;
         hist_number  <= 8'h0;
         hist_value   <= 16'h0;
         hist_hours   <= 32'h0;
      end else begin
         if (log_w) begin
            h_wp_q       <= h_wp_q + 3'h1;
            fault_number <= {5'h0, idx_d} + 8'h1;
            fault_time   <= hours_count;
         end
         hist_number <= h_num_q[h_rd_w];
         hist_value  <= h_val_q[h_rd_w];
         hist_hours  <= h_hrs_q[h_rd_w];
      end
   end

   // =========================================================
   // Trace: ten channels written in turn into one memory
   reg  [15:0] iv_q;
   reg  [6:0]  tw_q;
   reg  [3:0]  ch_q;
   reg  [6:0]  post_q;
   reg         trg_q;
   reg         busy_q;
   reg         smp_q;
   wire [15:0] ivl_w = (trace_interval_ms < `DSFS_TR_MIN_MS) ?
         `DSFS_TR_MIN_MS : (trace_interval_ms > `DSFS_TR_MAX_MS) ?
         `DSFS_TR_MAX_MS : trace_interval_ms;
   wire [15:0] trg_val_w = trace_in[trace_trig_ch*16 +: 16];
   wire trig_w = trace_trig_on_fault ? log_w :
                 (trg_val_w >= trace_trig_level);
   wire [15:0] ch_val_w = trace_in[ch_q*16 +: 16];
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         iv_q <= 16'h0;
         tw_q <= 7'h0;
         ch_q <= 4'h0;
         post_q <= 7'h0;
         trg_q <= 1'b0;
         busy_q <= 1'b0;
         smp_q <= 1'b0;
         trace_done <= 1'b0;
      end else begin
         if (arm_w && !busy_q) begin
            busy_q <= 1'b1;
            trg_q <= 1'b0;
            trace_done <= 1'b0;
         end
         if (busy_q && !trg_q && trig_w) begin
            trg_q  <= 1'b1;
            // Samples still to take after the trigger
            post_q <= 7'h7f - trace_delay;
         end
         if (ms_w && busy_q) begin
            iv_q <= (iv_q >= ivl_w - 16'h1) ? 16'h0 : iv_q + 16'h1;
            if (iv_q >= ivl_w - 16'h1) begin
               smp_q <= 1'b1;
               ch_q  <= 4'h0;
            end
         end
         if (smp_q) begin
            if (ch_q == `DSFS_TR_CH - 1) begin
               smp_q <= 1'b0;
               tw_q  <= tw_q + 7'h1;
               if (trg_q) begin
                  if (post_q == 7'h0) begin
                     busy_q <= 1'b0;
                     trace_done <= 1'b1;
                  end else begin
                     post_q <= post_q - 7'h1;
                  end
               end
            end else begin
               ch_q <= ch_q + 4'h1;
            end
         end
      end
   end
   dsfs_mem #(
      .AW (11),
      .DW (16)
   ) u_trace_mem (
      .clk   (clk),
      .we    (smp_q & busy_q),
      .waddr ({ch_q, tw_q}),
      .wdata (ch_val_w),
      .raddr (trace_raddr),
      .rdata (trace_rdata)
   );
endmodule

/* File: tb/dsfs_chk.sv */
/* Port assertions for dsfs_top.
   Bound from the bench top; sees only top-level ports. */
`timescale 1ns/1ps
module dsfs_chk (
   input wire        clk,
   input wire        rst_b,
   input wire        term_on,
   input wire        ser_on,
   input wire        term_enable,
   input wire        ser_enable,
   input wire        coast_stop_command_b,
   input wire        quick_stop_command_b,
   input wire        jog_request,
   input wire        jog_use_ramp,
   input wire [3:0]  alarm_src,
   input wire [15:0] motor_i2t,
   input wire        contactor_on,
   input wire        ctrl_enable,
   input wire        pulse_enable,
   input wire        speed_set_zero,
   input wire        jog_active,
   input wire        ramp_bypass,
   input wire        fault_out_b,
   input wire        alarm_out_b,
   input wire        fault_led
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // ========================================
   // Sequencer
   fault_off_a: assert property (
      !fault_out_b |-> !contactor_on && !pulse_enable && fault_led)
      else $error("drive active during fault");
   on_and_a: assert property (
      (!(term_on && ser_on) && !jog_request)[*8] |-> !$rose(contactor_on))
      else $error("contactor closed without switch-on");
   enable_needs_a: assert property (
      ctrl_enable |-> contactor_on)
      else $error("controllers on with contactor open");
   enable_loss_a: assert property (
      (!(term_enable && ser_enable))[*8] |-> !ctrl_enable)
      else $error("controllers on without enable");
   coast_stop_a: assert property (
      (!coast_stop_command_b)[*8] |-> !ctrl_enable)
      else $error("controllers on during coast stop");
   quick_zero_a: assert property (
      (!quick_stop_command_b)[*8] |-> speed_set_zero)
      else $error("setpoint not zero in quick stop");
   jog_contact_a: assert property (
      jog_active |-> contactor_on)
      else $error("jog without contactor");
   jog_bypass_a: assert property (
      (jog_active && !jog_use_ramp)[*6] |-> ramp_bypass)
      else $error("jog ramp not bypassed");
   // ========================================
   // Alarms
   i2t_alarm_a: assert property (
      (motor_i2t >= 16'h0064)[*6] |-> !alarm_out_b)
      else $error("overload alarm missing");
   alarm_clear_a: assert property (
      (motor_i2t < 16'h0064 && alarm_src == 4'h0)[*6] |-> alarm_out_b)
      else $error("alarm stuck without cause");
endmodule

/* File: tb/dsfs_drive_model.sv */
/* Motor and bridge model: speed and current seen by dsfs_top.
   Assumes the bench flags speed demand on accel. */
`timescale 1ns/1ps
module dsfs_drive_model (
   input  wire  clk,
   input  wire  rst_b,
   input  wire  accel,
   input  wire  ctrl_enable,
   input  wire  force_zero_current,
   input  wire  pulse_enable,
   output logic speed_below_min,
   output logic current_zero
);
   int         speed_q;
   logic [3:0] cur_q;
   // ========================================
   // Mechanics
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         speed_q <= 0;
         cur_q   <= 4'hf;
      end else begin
         // Current lags the bridge so stops must wait
         cur_q <= {cur_q[2:0], !pulse_enable || force_zero_current};
         if (accel && ctrl_enable && speed_q < 40)
            speed_q <= speed_q + 1;
         else if (!(accel && ctrl_enable) && speed_q > 0)
            speed_q <= speed_q - 1;
      end
   end
   assign speed_below_min = speed_q < 4;
   assign current_zero    = &cur_q;
endmodule

/* File: tb/dsfs_top_tb.sv */
/* Self-checking bench for dsfs_top with a load model.
   Assumes MS_CYC shortened to 10 cycles per ms. */
`timescale 1ns/1ps
module dsfs_top_tb;
   logic clk, rst_b, term_on, ser_on, term_enable, ser_enable;
   logic coast_stop_command_b, quick_stop_command_b, jog_request;
   logic jog_use_ramp, speed_below_min, current_zero, ack_panel;
   logic ack_input, ack_serial, trace_trig_on_fault, trace_arm;
   logic [15:0] brake_delay_ms, field_delay_ms, jog_off_delay_ms;
   logic [15:0] restart_ms, fault_value, motor_i2t, trace_trig_level;
   logic [15:0] trace_interval_ms, trace_rdata, hist_value;
   logic [7:0] fault_src, fault_dis_clr, fault_dis_set, fault_number;
   logic [7:0] hist_number;
   logic [3:0] alarm_src, trace_trig_ch;
   logic [31:0] hours_count, fault_time, hist_hours;
   logic [159:0] trace_in;
   logic [6:0] trace_delay;
   logic [10:0] trace_raddr;
   logic [2:0] hist_sel;
   logic contactor_on, ctrl_enable, force_zero_current, pulse_enable;
   logic speed_set_zero, quick_limit_sel, jog_active, ramp_bypass;
   logic field_standstill, fault_out_b, alarm_out_b, fault_led;
   logic trace_done;
   logic [55:0] hq[$];
   int seed = 85067;
   int fail_count = 0;
   int n_compared = 0;
   wire accel = (term_on && ser_on || jog_request) && quick_stop_command_b;
   wire [7:0] obs = {contactor_on, ctrl_enable, pulse_enable, fault_out_b,
                     alarm_out_b, jog_active, field_standstill, trace_done};

   dsfs_top #(.MS_CYC(10)) uut (.*);
   dsfs_drive_model u_drive (
      .clk(clk), .rst_b(rst_b), .accel(accel), .ctrl_enable(ctrl_enable),
      .force_zero_current(force_zero_current),
      .pulse_enable(pulse_enable), .speed_below_min(speed_below_min),
      .current_zero(current_zero));

   // ========================================
   // Helpers
   task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic step(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wait_obs(int i, logic v, string nm);
      int k;
      k = 0;
      while (obs[i] !== v && k < 6000) begin
         step(1);
         k++;
      end
      check(nm, obs[i], v);
   endtask
   // Raise fault s, check the record, acknowledge via source a
   task automatic trip(int s, int a);
      fault_value = 16'($random(seed));
      hours_count = $random(seed);
      fault_src[s] = 1'b1;
      wait_obs(4, 1'b0, "fault_out_b");
      check("fault_number", fault_number, s + 1);
      check("fault_time", fault_time, hours_count);
      hq.push_front({8'(s + 1), fault_value, hours_count});
      if (hq.size() > 8) hq.pop_back();
      fault_src[s] = 1'b0;
      step(4);
      {ack_panel, ack_input, ack_serial} = 3'h4 >> a;
      step(6);
      {ack_panel, ack_input, ack_serial} = 3'h0;
      wait_obs(4, 1'b1, "fault acknowledged");
   endtask
   task automatic complete_run;
      $display("Compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // ========================================
   // Clock and watchdog
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      repeat (60000) @(posedge clk);
      fail_count++;
      complete_run();
   end

   // ========================================
   // Scenarios
   initial begin
      {rst_b, term_on, ser_on, jog_request, jog_use_ramp} = 5'h0;
      {term_enable, ser_enable, coast_stop_command_b} = 3'h7;
      {quick_stop_command_b, trace_trig_on_fault, trace_arm} = 3'h7;
      {ack_panel, ack_input, ack_serial} = 3'h0;
      {brake_delay_ms, field_delay_ms} = {16'h0002, 16'h0003};
      {jog_off_delay_ms, restart_ms} = {16'h0001, 16'h0005};
      {fault_value, hours_count, motor_i2t} = 64'h0;
      {fault_src, fault_dis_clr, fault_dis_set, alarm_src} = 28'h0;
      {trace_trig_ch, trace_trig_level, trace_delay} = {4'h0, 16'hffff, 7'h10};
      {trace_interval_ms, trace_raddr, hist_sel} = {16'h0003, 11'h0, 3'h0};
      for (int c = 0; c < 10; c++) trace_in[c*16 +: 16] = 16'h0a00 + c;
      step(20);
      rst_b = 1'b1;
      step(4);
      term_on = 1'b1;
      step(20);
      check("contactor_on", contactor_on, 1'b0);
      ser_on = 1'b1;
      wait_obs(6, 1'b1, "ctrl_enable");
      step(30);
      term_on = 1'b0;
      wait_obs(7, 1'b0, "contactor_on stop");
      check("ctrl_enable", ctrl_enable, 1'b0);
      step(20);
      check("field_standstill early", field_standstill, 1'b0);
      wait_obs(1, 1'b1, "field_standstill");
      // Enable loss, coast stop, quick stop, then coast with quick
      for (int m = 0; m < 4; m++) begin
         term_on = 1'b1;
         wait_obs(6, 1'b1, "ctrl_enable");
         step(30);
         {ser_enable, coast_stop_command_b, quick_stop_command_b} =
            3'h7 ^ (m == 3 ? 3'h3 : 3'h4 >> m);
         step(5);
         check("force_zero", force_zero_current, m != 2);
         check("quick_limit_sel", quick_limit_sel, m == 2);
         wait_obs(m == 0 ? 5 : 7, 1'b0, "stop reached");
         check("pulse_enable", pulse_enable, 1'b0);
         if (m == 2) check("speed_set_zero", speed_set_zero, 1'b1);
         term_on = 1'b0;
         step(10);
         {ser_enable, coast_stop_command_b, quick_stop_command_b} = 3'h7;
         step(10);
      end
      // Jog is refused without enable, then runs with ramp bypass
      {term_enable, jog_request} = 2'h1;
      step(30);
      check("jog refused", jog_active, 1'b0);
      term_enable = 1'b1;
      wait_obs(2, 1'b1, "jog_active");
      step(6);
      check("ramp_bypass", ramp_bypass, 1'b1);
      jog_use_ramp = 1'b1;
      step(6);
      check("ramp_bypass ramp", ramp_bypass, 1'b0);
      jog_request = 1'b0;
      wait_obs(7, 1'b0, "contactor after jog");
      // Fault while running, then starting lockout
      term_on = 1'b1;
      wait_obs(7, 1'b1, "contactor_on");
      trip(5, 0);
      step(20);
      check("lockout", contactor_on, 1'b0);
      term_on = 1'b0;
      step(10);
      term_on = 1'b1;
      wait_obs(7, 1'b1, "restart after lockout");
      motor_i2t = 16'h0064;
      wait_obs(3, 1'b0, "i2t alarm");
      step(20);
      check("alarm keeps drive", contactor_on, 1'b1);
      motor_i2t = 16'h0063;
      wait_obs(3, 1'b1, "alarm cleared");
      alarm_src = 4'h2;
      wait_obs(3, 1'b0, "source alarm");
      alarm_src = 4'h0;
      term_on = 1'b0;
      // Short supply dip rides through the restart window
      fault_src[0] = 1'b1;
      step(10);
      fault_src[0] = 1'b0;
      step(80);
      check("ride through", fault_out_b, 1'b1);
      restart_ms = 16'h0000;
      trip(0, 1);
      fault_dis_set = 8'h20;
      step(1);
      fault_dis_set = 8'h00;
      fault_src = 8'ha0;
      step(30);
      check("disabled sources", fault_out_b, 1'b1);
      fault_src = 8'h00;
      fault_dis_clr = 8'h20;
      step(1);
      fault_dis_clr = 8'h00;
      for (int a = 0; a < 9; a++) trip(a % 2 ? 6 : 5, a % 3);
      for (int i = 0; i < 8; i++) begin
         hist_sel = 3'(i);
         step(3);
         check("hist_number", hist_number, hq[i][55:48]);
         check("hist_value", hist_value, hq[i][47:32]);
         check("hist_hours", hist_hours, hq[i][31:0]);
      end
      wait_obs(0, 1'b1, "trace_done");
      trace_raddr = {4'h3, 7'h05};
      step(2);
      check("trace_rdata", trace_rdata, 16'h0a03);
      complete_run();
   end
endmodule

bind dsfs_top dsfs_chk u_chk (.*);
